// [dma_irq_endpoint_strobe_ctrl.sv]
// dma interrupt enables, endpoint select, strobe timing and burst count
`timescale 1ns/1ps
`include "dma_cfg_defs.svh"

module dma_irq_endpoint_strobe_ctrl (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   input  wire logic                  usb_bus_reset,
   // host register port
   input  wire dma_cfg_pkg::host_req_t host_req,
   output logic [15:0]                rdata,
   output logic                       rd_valid,
   // reason register outside
   input  wire logic [15:0]           reason_bits,
   output logic [15:0]                reason_clear,
   input  wire logic                  test_status_readonly,
   // dma engine
   input  wire dma_cfg_pkg::dma_mode_t dma_mode,
   input  wire logic                  strobe_start,
   output logic                       strobe,
   output dma_cfg_pkg::ep_sel_t       ep_sel,
   output logic [12:0]                burst_length_count,
   output logic                       dma_irq
);

   logic [15:0] irq_en;
   logic [4:0]  strobe_cycle_count;
   logic        wr_en;
   logic        wr_ep;
   logic        wr_strobe;
   logic        wr_burst;
   logic        wr_reason;
   logic        master_on;
   logic [15:0] next_rdata;
   logic [15:0] en_view;

   assign wr_en     = host_req.wr && (host_req.addr == `DMA_IRQ_EN_OFS);
   assign wr_ep     = host_req.wr && (host_req.addr == `DMA_EP_SEL_OFS);
   assign wr_strobe = host_req.wr && (host_req.addr == `DMA_STROBE_OFS);
   assign wr_burst  = host_req.wr && (host_req.addr == `DMA_BURST_OFS);
   assign wr_reason = host_req.wr && (host_req.addr == `DMA_REASON_OFS);
   assign master_on = (dma_mode == dma_cfg_pkg::master_dma_mode);

   //////////////////////////////////////////////////////////////////////////
   // interrupt enables; only bits 12:8 and 4:1 are storage
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_en <= `DMA_IRQ_EN_RST;
      end else if (usb_bus_reset) begin
         irq_en <= `DMA_IRQ_EN_RST;
      end else if (wr_en) begin
         irq_en <= host_req.wdata & `DMA_IRQ_EN_WMASK;
      end
   end

   // top bit shows the test status, never an enable
   always_comb begin
      en_view = irq_en;
      en_view[`DMA_TEST_STATUS_BIT] = test_status_readonly;
   end

   // reason store lives outside; a written one in bits 12:8 or 4:1 is passed on as a clear
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reason_clear <= 16'h0000;
      end else if (wr_reason) begin
         reason_clear <= host_req.wdata & `DMA_IRQ_EN_WMASK;
      end else begin
         reason_clear <= 16'h0000;
      end
   end

   // reason bit 15 has no enable, so it can never raise the line
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dma_irq <= 1'b0;
      end else begin
         dma_irq <= |(reason_bits & irq_en);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // endpoint select; keeping it off the general index is up to software
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ep_sel <= `DMA_EP_SEL_RST;
      end else if (usb_bus_reset) begin
         ep_sel <= `DMA_EP_SEL_RST;
      end else if (wr_ep) begin
         ep_sel.dma_ep_number <=
            host_req.wdata[`DMA_EP_NUM_MSB:`DMA_EP_NUM_LSB];
         ep_sel.dma_direction <= host_req.wdata[`DMA_EP_DIR_BIT];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // strobe timing and burst counter
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         strobe_cycle_count <= `DMA_STROBE_RST;
      end else if (usb_bus_reset) begin
         strobe_cycle_count <= `DMA_STROBE_RST;
      end else if (wr_strobe) begin
         strobe_cycle_count <= host_req.wdata[`DMA_STROBE_MSB:0];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         burst_length_count <= `DMA_BURST_RST;
      end else if (usb_bus_reset) begin
         burst_length_count <= `DMA_BURST_RST;
      end else if (wr_burst) begin
         burst_length_count <= host_req.wdata[`DMA_BURST_MSB:0];
      end
   end

   // other modes time their strobes elsewhere, so starts are dropped here
   strobe_timer u_strobe (
      .mclk               (mclk),
      .sys_rst            (sys_rst),
      .start              (strobe_start && master_on),
      .strobe_cycle_count (strobe_cycle_count),
      .strobe             (strobe)
   );

   //////////////////////////////////////////////////////////////////////////
   // read back, one cycle after the request; unmapped reads give zero
   always_comb begin
      case (host_req.addr)
         `DMA_REASON_OFS: next_rdata = reason_bits;
         `DMA_IRQ_EN_OFS: next_rdata = en_view;
         `DMA_EP_SEL_OFS: next_rdata = {12'h000, ep_sel};
         `DMA_STROBE_OFS: next_rdata = {11'h000, strobe_cycle_count};
         `DMA_BURST_OFS:  next_rdata = {3'h0, burst_length_count};
         default:         next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata    <= 16'h0000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= host_req.rd;
         if (host_req.rd) begin
            rdata <= next_rdata;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks
   property p_en_write;
      @(posedge mclk) disable iff (sys_rst)
         (wr_en && !usb_bus_reset) |=>
            irq_en == ($past(host_req.wdata) & `DMA_IRQ_EN_WMASK);
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("enable register did not take masked write");

   property p_irq_gate;
      @(posedge mclk) disable iff (sys_rst)
         ##1 dma_irq == |($past(reason_bits) & $past(irq_en));
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt not gated by enables");

   property p_bus_reset_clear;
      @(posedge mclk) disable iff (sys_rst)
         usb_bus_reset |=> (irq_en == 16'h0000) && (ep_sel == 4'h0)
            && (strobe_cycle_count == 5'h1f);
   endproperty
   a_bus_reset_clear: assert property (p_bus_reset_clear)
      else $error("bus reset did not restore registers");

   property p_reason_clear;
      @(posedge mclk) disable iff (sys_rst)
         wr_reason |=> reason_clear == ($past(host_req.wdata) & 16'h1f1e);
   endproperty
   a_reason_clear: assert property (p_reason_clear)
      else $error("reason write not forwarded as clear");

   property p_ep_write;
      @(posedge mclk) disable iff (sys_rst)
         (wr_ep && !usb_bus_reset) |=>
            ep_sel.dma_ep_number == $past(host_req.wdata[3:1]);
   endproperty
   a_ep_write: assert property (p_ep_write)
      else $error("endpoint number not taken from bits 3 to 1");

   property p_dir_write;
      @(posedge mclk) disable iff (sys_rst)
         (wr_ep && !usb_bus_reset) |=>
            ep_sel.dma_direction == $past(host_req.wdata[0]);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction not taken from bit 0");

   property p_master_only;
      @(posedge mclk) disable iff (sys_rst)
         (!strobe && !(strobe_start && master_on)) |=> !strobe;
   endproperty
   a_master_only: assert property (p_master_only)
      else $error("strobe started outside master dma mode");

   property p_burst_read;
      @(posedge mclk) disable iff (sys_rst)
         (host_req.rd && host_req.addr == `DMA_BURST_OFS) |=>
            rd_valid && rdata == {3'h0, $past(burst_length_count)};
   endproperty
   a_burst_read: assert property (p_burst_read)
      else $error("burst counter read back wrong");

   property p_irq_holds;
      @(posedge mclk) disable iff (sys_rst)
         (|(reason_bits & irq_en)) [*2] |-> dma_irq;
   endproperty
   a_irq_holds: assert property (p_irq_holds)
      else $error("interrupt dropped while a pair is active");

endmodule

// [dma_cfg_defs.svh]
// offsets, field positions, reset values and timing counts of the dma slice
`ifndef DMA_CFG_DEFS_SVH
`define DMA_CFG_DEFS_SVH

`define DMA_REASON_OFS     8'h50
`define DMA_IRQ_EN_OFS     8'h54
`define DMA_EP_SEL_OFS     8'h58
`define DMA_STROBE_OFS     8'h60
`define DMA_BURST_OFS      8'h64

`define DMA_IRQ_EN_RST     16'h0000
`define DMA_IRQ_EN_WMASK   16'h1f1e
`define DMA_TEST_STATUS_BIT 15

`define DMA_EP_SEL_RST     4'h0
`define DMA_EP_DIR_BIT     0
`define DMA_EP_NUM_LSB     1
`define DMA_EP_NUM_MSB     3

`define DMA_STROBE_RST     5'h1f
`define DMA_STROBE_MSB     4

`define DMA_BURST_RST      13'h0000
`define DMA_BURST_MSB      12

`define DMA_MASTER_MODE    2'h3

`define DMA_MCLK_PERIOD_PS 10000
`define DMA_INT_CYCLE_PS   33300
`define DMA_INT_CYCLE_CLKS \
   ((`DMA_INT_CYCLE_PS + `DMA_MCLK_PERIOD_PS - 1) / `DMA_MCLK_PERIOD_PS)

`endif

// [dma_cfg_pkg.sv]
// types shared by the dma configuration slice
package dma_cfg_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } host_req_t;

   typedef struct packed {
      logic [2:0] dma_ep_number;
      logic       dma_direction;
   } ep_sel_t;

   typedef enum logic [1:0] {
      generic_dma_mode_slave,
      mode_rsvd_1,
      mode_rsvd_2,
      master_dma_mode
   } dma_mode_t;

endpackage

// [strobe_timer.sv]
// master dma strobe generator, (n+1) internal cycles long
`timescale 1ns/1ps
`include "dma_cfg_defs.svh"

module strobe_timer (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // request
   input  wire logic       start,
   input  wire logic [4:0] strobe_cycle_count,
   // strobe
   output logic            strobe
);

   localparam int TICKS = `DMA_INT_CYCLE_CLKS;

   logic [2:0] tick;
   logic [4:0] left;
   logic       tick_end;
   logic       last;

   assign tick_end = (tick == 3'(TICKS - 1));
   assign last     = tick_end && (left == 5'h00);

   //////////////////////////////////////////////////////////////////////////
   // one internal cycle is rounded up to whole mclk periods
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tick <= 3'h0;
      end else if (!strobe || tick_end) begin
         tick <= 3'h0;
      end else begin
         tick <= tick + 3'h1;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         left <= 5'h00;
      end else if (!strobe && start) begin
         left <= strobe_cycle_count;
      end else if (strobe && tick_end) begin
         left <= left - 5'h01;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         strobe <= 1'b0;
      end else if (!strobe && start) begin
         strobe <= 1'b1;
      end else if (strobe && last) begin
         strobe <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checking helpers
   logic [9:0] hi_cnt;
   logic [4:0] len_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hi_cnt <= 10'h000;
         len_q  <= 5'h00;
      end else if (!strobe && start) begin
         hi_cnt <= 10'h000;
         len_q  <= strobe_cycle_count;
      end else if (strobe) begin
         hi_cnt <= hi_cnt + 10'h001;
      end
   end

   property p_strobe_len;
      @(posedge mclk) disable iff (sys_rst)
         (strobe && last) |->
            (hi_cnt + 10'h001) == 10'((len_q + 10'h001) * TICKS);
   endproperty
   a_strobe_len: assert property (p_strobe_len)
      else $error("strobe length not (n+1) internal cycles");

   property p_tick_period;
      @(posedge mclk) disable iff (sys_rst)
         $rose(strobe) |-> (tick == 3'h0) ##3 tick_end;
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("internal cycle tick misaligned at strobe start");

endmodule

// [reason_source_model.sv]
// host side model of the dma interrupt reason register
`timescale 1ns/1ps

module reason_source_model (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // events and clears
   input  wire logic [15:0] set_bits,
   input  wire logic [15:0] reason_clear,
   // reason contents
   output logic [15:0]      reason_bits
);
   // set wins over clear: a fresh event must not be lost
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reason_bits <= 16'h0000;
      end else begin
         reason_bits <= (reason_bits & ~reason_clear) | set_bits;
      end
   end
endmodule

// [tb_dma_irq_endpoint_strobe_ctrl.sv]
// self-checking bench for the dma enable, endpoint and strobe slice
`timescale 1ns/1ps

`define CHK(what, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("ERROR %s exp %h got %h", what, exp, got); \
      end \
   end

module tb_dma_irq_endpoint_strobe_ctrl;
   logic                   mclk;
   logic                   sys_rst;
   logic                   usb_bus_reset;
   dma_cfg_pkg::host_req_t host_req;
   logic [15:0]            rdata;
   logic                   rd_valid;
   logic [15:0]            reason_bits;
   logic [15:0]            reason_clear;
   logic [15:0]            set_bits;
   logic                   test_status_readonly;
   dma_cfg_pkg::dma_mode_t dma_mode;
   logic                   strobe_start;
   logic                   strobe;
   dma_cfg_pkg::ep_sel_t   ep_sel;
   logic [12:0]            burst_length_count;
   logic                   dma_irq;
   int                     n_mismatch;
   int                     check_count;

   dma_irq_endpoint_strobe_ctrl i_dut (
      .mclk                 (mclk),
      .sys_rst              (sys_rst),
      .usb_bus_reset        (usb_bus_reset),
      .host_req             (host_req),
      .rdata                (rdata),
      .rd_valid             (rd_valid),
      .reason_bits          (reason_bits),
      .reason_clear         (reason_clear),
      .test_status_readonly (test_status_readonly),
      .dma_mode             (dma_mode),
      .strobe_start         (strobe_start),
      .strobe               (strobe),
      .ep_sel               (ep_sel),
      .burst_length_count   (burst_length_count),
      .dma_irq              (dma_irq)
   );

   reason_source_model i_reason (
      .mclk         (mclk),
      .sys_rst      (sys_rst),
      .set_bits     (set_bits),
      .reason_clear (reason_clear),
      .reason_bits  (reason_bits)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic timeout();
      n_mismatch++;
      conclude();
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk) #1;
      host_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge mclk) #1;
      host_req.wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      int i;
      @(posedge mclk) #1;
      host_req.addr = a;
      host_req.rd = 1'b1;
      @(posedge mclk) #1;
      host_req.rd = 1'b0;
      for (i = 0; i < 4 && rd_valid !== 1'b1; i++) @(posedge mclk) #1;
      if (i == 4) timeout();
      `CHK("rdata", e, rdata)
   endtask

   // one-cycle event into the reason model
   task automatic raise(input logic [15:0] b);
      @(posedge mclk) #1;
      set_bits = b;
      @(posedge mclk) #1;
      set_bits = 16'h0000;
   endtask

   // writes count n, starts a strobe, counts its high cycles
   task automatic strobe_len(input logic [4:0] n, input int exp);
      int len;
      int i;
      wr(8'h60, {11'h000, n});
      @(posedge mclk) #1;
      strobe_start = 1'b1;
      @(posedge mclk) #1;
      strobe_start = 1'b0;
      len = 0;
      for (i = 0; i < 140 && !(len > 0 && strobe !== 1'b1); i++) begin
         if (strobe === 1'b1) len++;
         @(posedge mclk) #1;
      end
      if (i == 140 && exp != 0) timeout();
      `CHK("strobe cycles", exp, len)
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      n_mismatch = 0;
      check_count = 0;
      sys_rst = 1'b1;
      usb_bus_reset = 1'b0;
      host_req = '0;
      set_bits = 16'h0000;
      test_status_readonly = 1'b0;
      dma_mode = dma_cfg_pkg::master_dma_mode;
      strobe_start = 1'b0;
      repeat (5) @(posedge mclk);
      #1 sys_rst = 1'b0;
      rd(8'h54, 16'h0000);
      rd(8'h58, 16'h0000);
      rd(8'h60, 16'h001f);
      rd(8'h64, 16'h0000);
      rd(8'h70, 16'h0000);
      wr(8'h54, 16'hffff);
      rd(8'h54, 16'h1f1e);
      test_status_readonly = 1'b1;
      rd(8'h54, 16'h9f1e);
      // masked source must stay silent
      wr(8'h54, 16'h0000);
      raise(16'h0100);
      repeat (2) @(posedge mclk) #1;
      `CHK("irq masked", 1'b0, dma_irq)
      wr(8'h54, 16'h0100);
      @(posedge mclk) #1;
      `CHK("irq on", 1'b1, dma_irq)
      rd(8'h50, 16'h0100);
      wr(8'h50, 16'hffff);
      `CHK("clear mask", 16'h1f1e, reason_clear)
      repeat (2) @(posedge mclk) #1;
      `CHK("irq off", 1'b0, dma_irq)
      // no general index exists here, so any endpoint is free for dma
      wr(8'h58, 16'h00ff);
      rd(8'h58, 16'h000f);
      `CHK("ep sel", 4'hf, ep_sel)
      wr(8'h58, 16'h000a);
      rd(8'h58, 16'h000a);
      `CHK("ep sel", 4'ha, ep_sel)
      wr(8'h64, 16'hffff);
      rd(8'h64, 16'h1fff);
      `CHK("burst", 13'h1fff, burst_length_count)
      strobe_len(5'h00, 4);
      strobe_len(5'h02, 12);
      for (int m = 0; m < 3; m++) begin
         dma_mode = dma_cfg_pkg::dma_mode_t'(m);
         strobe_len(5'h00, 0);
      end
      dma_mode = dma_cfg_pkg::master_dma_mode;
      // bus reset with an enabled pending source
      wr(8'h54, 16'h1f1e);
      raise(16'h1000);
      @(posedge mclk) #1;
      `CHK("irq pre", 1'b1, dma_irq)
      usb_bus_reset = 1'b1;
      @(posedge mclk) #1;
      usb_bus_reset = 1'b0;
      @(posedge mclk) #1;
      `CHK("irq bus reset", 1'b0, dma_irq)
      test_status_readonly = 1'b0;
      rd(8'h54, 16'h0000);
      rd(8'h58, 16'h0000);
      rd(8'h60, 16'h001f);
      rd(8'h64, 16'h0000);
      conclude();
   end
endmodule
